//--- core/ufg_gate.v
// Notes on behaviour
// - entry 0x00 enters serial programming mode until serial exit resets
// - key validates a call only if written at most 6 cycles before
// - single-byte read leaves the fetched flash byte in read data
// - block read and write length comes from the byte count register
// - no interrupt is taken while a routine runs, whatever enable says
// - global enable kept; pending interrupts serviced after return
// - repeat interrupt from an already pending source is dropped
// - serial mode checks security; secured allows only three commands
// - user entry points skip the security check entirely
// - routines service the watchdog periodically while running
// - on return the watchdog is serviced and its lower window enabled
// - entry 0x17 erases the page at the address registers
// - entry 0x62 resets the device
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "ufg_map.vh"

module ufg_gate #(
	parameter        NIRQ        = 4,
	parameter [31:0] WDT_SVC_CYC = `UFG_WDT_SVC_CYC
) (
	// clock and reset
	input  wire              MCLK,
	input  wire              RST,
	// avalon-mm slave
	input  wire [7:0]        AVS_ADDRESS,
	input  wire              AVS_READ,
	input  wire              AVS_WRITE,
	input  wire [31:0]       AVS_WRITEDATA,
	output reg  [31:0]       AVS_READDATA,
	output wire              AVS_WAITREQUEST,
	// flash array
	output reg  [15:0]       FL_ADDR,
	output reg  [7:0]        FL_WDATA,
	output wire [7:0]        FL_TIMING,
	output reg               FL_READ,
	output reg               FL_WRITE,
	output reg               FL_PAGE_ERASE,
	output reg               FL_MASS_ERASE,
	input  wire [7:0]        FL_RDATA,
	input  wire              FL_DONE,
	// ram for block transfers
	output wire [7:0]        RAM_ADDR,
	output reg               RAM_READ,
	output reg               RAM_WRITE,
	output reg  [7:0]        RAM_WDATA,
	input  wire [7:0]        RAM_RDATA,
	// interrupts
	input  wire [NIRQ-1:0]   IRQ_SRC,
	input  wire [NIRQ-1:0]   IRQ_ACK,
	output wire [NIRQ-1:0]   IRQ_PENDING,
	output wire              CPU_IRQ,
	// watchdog
	output reg               WDT_SERVICE,
	output reg               WDT_LOWER_EN,
	// serial programming mode
	input  wire              SEC_BIT,
	input  wire              SER_VALID,
	input  wire [7:0]        SER_CMD,
	output reg               SER_ACCEPT,
	output reg               SER_REJECT,
	output wire              ISP_MODE,
	// device reset request
	output reg               DEV_RESET
);

	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_ISSUE = 4'h1;
	localparam [3:0] S_WAIT  = 4'h2;
	localparam [3:0] S_FETCH = 4'h3;
	localparam [3:0] S_RAMW  = 4'h4;
	localparam [3:0] S_DONE  = 4'h5;
	localparam [3:0] S_RAMD  = 4'h6;

	reg [7:0]      addr_low;
	reg [7:0]      addr_high;
	reg [7:0]      read_data;
	reg [7:0]      write_data;
	reg [7:0]      write_timing;
	reg [7:0]      unlock_key;
	reg [7:0]      byte_count;
	reg [7:0]      accum;
	reg [7:0]      xptr;
	reg            global_interrupt_enable;
	reg [3:0]      key_age;
	reg [1:0]      result;
	reg            isp_mode;
	reg [NIRQ-1:0] pend;
	reg [3:0]      st;
	reg [7:0]      kind;
	reg [7:0]      cnt;
	reg [15:0]     op_addr;
	reg [31:0]     wdt_cnt;
	reg            rd_ack;
	reg [31:0]     next_rdata;

	wire busy     = (st != S_IDLE);
	wire sel_w    = AVS_WRITE & ~busy;
	wire call_go  = sel_w & (AVS_ADDRESS == `UFG_OFS_CALL);
	wire key_live = (unlock_key == `UFG_KEY_VALUE) &&
	                (key_age < `UFG_KEY_WIN_CYC);
	wire [7:0] wd = AVS_WRITEDATA[7:0];

	// writes stall while a routine runs, as the core would be held
	assign AVS_WAITREQUEST = (AVS_READ & ~rd_ack) | (AVS_WRITE & busy);
	assign FL_TIMING   = write_timing;
	assign RAM_ADDR    = xptr;
	assign IRQ_PENDING = pend;
	assign ISP_MODE    = isp_mode;
	// pending requests wait until the routine has returned
	assign CPU_IRQ     = global_interrupt_enable & (|pend) & ~busy;

	////////////////////////////////////////////////////////////////////
	// register read mux

	always @* begin
		next_rdata = 32'h0000_0000;
		case (AVS_ADDRESS)
			`UFG_OFS_ADDR_LOW:   next_rdata[7:0] = addr_low;
			`UFG_OFS_ADDR_HIGH:  next_rdata[7:0] = addr_high;
			`UFG_OFS_READ_DATA:  next_rdata[7:0] = read_data;
			`UFG_OFS_WRITE_DATA: next_rdata[7:0] = write_data;
			`UFG_OFS_WR_TIMING:  next_rdata[7:0] = write_timing;
			`UFG_OFS_UNLOCK_KEY: next_rdata[7:0] = unlock_key;
			`UFG_OFS_BYTE_COUNT: next_rdata[7:0] = byte_count;
			`UFG_OFS_ACCUM:      next_rdata[7:0] = accum;
			`UFG_OFS_XPTR:       next_rdata[7:0] = xptr;
			`UFG_OFS_CTRL:       next_rdata[`UFG_CTRL_GIE] = global_interrupt_enable;
			`UFG_OFS_STATUS: begin
				next_rdata[`UFG_ST_BUSY]     = busy;
				next_rdata[`UFG_ST_ISP]      = isp_mode;
				next_rdata[`UFG_ST_RES_LO+1:`UFG_ST_RES_LO] = result;
				next_rdata[`UFG_ST_KEY_LIVE] = key_live;
			end
			`UFG_OFS_IRQ_PEND:   next_rdata[NIRQ-1:0] = pend;
			default:             next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge MCLK) begin
		if (RST) begin
			rd_ack       <= 1'b0;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			rd_ack <= AVS_READ & ~rd_ack;
			if (AVS_READ & ~rd_ack)
				AVS_READDATA <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt pending bits; a new request beats a same-cycle ack

	always @(posedge MCLK) begin
		if (RST)
			pend <= {NIRQ{1'b0}};
		else
			pend <= (pend & ~IRQ_ACK) | IRQ_SRC;
	end

	////////////////////////////////////////////////////////////////////
	// key age counts cycles since the key register was last written

	always @(posedge MCLK) begin
		if (RST)
			key_age <= 4'hf;
		else if (sel_w && AVS_ADDRESS == `UFG_OFS_UNLOCK_KEY)
			key_age <= 4'h0;
		else if (key_age != 4'hf)
			key_age <= key_age + 4'h1;
	end

	////////////////////////////////////////////////////////////////////
	// serial programming mode commands

	always @(posedge MCLK) begin
		if (RST) begin
			SER_ACCEPT <= 1'b0;
			SER_REJECT <= 1'b0;
		end else begin
			SER_ACCEPT <= 1'b0;
			SER_REJECT <= 1'b0;
			if (isp_mode && SER_VALID && SER_CMD != `UFG_SER_EXIT) begin
				// secured parts keep only erase, timing and option read
				if (SEC_BIT && SER_CMD != `UFG_SER_MASS_ERASE &&
				    SER_CMD != `UFG_SER_WR_TIMING &&
				    SER_CMD != `UFG_SER_RD_OPTION)
					SER_REJECT <= 1'b1;
				else
					SER_ACCEPT <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers and call sequencer

	always @(posedge MCLK) begin
		if (RST) begin
			addr_low      <= `UFG_RST_REG;
			addr_high     <= `UFG_RST_REG;
			read_data     <= `UFG_RST_REG;
			write_data    <= `UFG_RST_REG;
			write_timing  <= `UFG_RST_REG;
			unlock_key    <= `UFG_RST_REG;
			byte_count    <= `UFG_RST_REG;
			accum         <= `UFG_RST_REG;
			xptr          <= `UFG_RST_REG;
			global_interrupt_enable           <= 1'b0;
			result        <= `UFG_RES_OK;
			isp_mode      <= 1'b0;
			st            <= S_IDLE;
			kind          <= 8'h00;
			cnt           <= 8'h00;
			op_addr       <= 16'h0000;
			wdt_cnt       <= 32'h0000_0000;
			FL_ADDR       <= 16'h0000;
			FL_WDATA      <= 8'h00;
			FL_READ       <= 1'b0;
			FL_WRITE      <= 1'b0;
			FL_PAGE_ERASE <= 1'b0;
			FL_MASS_ERASE <= 1'b0;
			RAM_READ      <= 1'b0;
			RAM_WRITE     <= 1'b0;
			RAM_WDATA     <= 8'h00;
			WDT_SERVICE   <= 1'b0;
			WDT_LOWER_EN  <= 1'b0;
			DEV_RESET     <= 1'b0;
		end else begin
			FL_READ       <= 1'b0;
			FL_WRITE      <= 1'b0;
			FL_PAGE_ERASE <= 1'b0;
			FL_MASS_ERASE <= 1'b0;
			RAM_READ      <= 1'b0;
			RAM_WRITE     <= 1'b0;
			WDT_SERVICE   <= 1'b0;
			WDT_LOWER_EN  <= 1'b0;
			if (isp_mode && SER_VALID && SER_CMD == `UFG_SER_EXIT)
				DEV_RESET <= 1'b1;
			if (sel_w) begin
				case (AVS_ADDRESS)
					`UFG_OFS_ADDR_LOW:   addr_low     <= wd;
					`UFG_OFS_ADDR_HIGH:  addr_high    <= wd;
					`UFG_OFS_READ_DATA:  read_data    <= wd;
					`UFG_OFS_WRITE_DATA: write_data   <= wd;
					`UFG_OFS_WR_TIMING:  write_timing <= wd;
					`UFG_OFS_UNLOCK_KEY: unlock_key   <= wd;
					`UFG_OFS_BYTE_COUNT: byte_count   <= wd;
					`UFG_OFS_ACCUM:      accum        <= wd;
					`UFG_OFS_XPTR:       xptr         <= wd;
					`UFG_OFS_CTRL:       global_interrupt_enable <= wd[`UFG_CTRL_GIE];
					default: ;
				endcase
			end
			// a block read moves the pointer only once its ram write is out
			if (RAM_WRITE)
				xptr <= xptr + 8'h01;
			// watchdog kept alive during long routines
			if (busy && st != S_DONE) begin
				if (wdt_cnt >= WDT_SVC_CYC - 32'd1) begin
					wdt_cnt     <= 32'h0000_0000;
					WDT_SERVICE <= 1'b1;
				end else
					wdt_cnt <= wdt_cnt + 32'd1;
			end else
				wdt_cnt <= 32'h0000_0000;
			case (st)
				S_IDLE: if (call_go) begin
					// a call spends the key, valid or not
					unlock_key <= `UFG_RST_REG;
					kind       <= wd;
					op_addr    <= {addr_high, addr_low};
					FL_ADDR    <= {addr_high, addr_low};
					cnt        <= byte_count;
					result     <= `UFG_RES_OK;
					// no security check on user entry points
					if (!key_live)
						result <= `UFG_RES_BAD_KEY;
					else begin
						case (wd)
							`UFG_EP_SERIAL:
								isp_mode <= 1'b1;
							`UFG_EP_EXIT:
								DEV_RESET <= 1'b1;
							`UFG_EP_READ_BYTE: begin
								FL_READ <= 1'b1;
								st      <= S_WAIT;
							end
							`UFG_EP_WRITE_BYTE: begin
								FL_WDATA <= write_data;
								FL_WRITE <= 1'b1;
								st       <= S_WAIT;
							end
							`UFG_EP_PAGE_ERASE: begin
								FL_PAGE_ERASE <= 1'b1;
								st            <= S_WAIT;
							end
							`UFG_EP_MASS_ERASE:
								if (accum == `UFG_CONFIRM) begin
									FL_MASS_ERASE <= 1'b1;
									st            <= S_WAIT;
								end else
									result <= `UFG_RES_BAD_CONF;
							`UFG_EP_BLOCK_READ:
								st <= (byte_count == 8'h00) ?
								      S_DONE : S_ISSUE;
							`UFG_EP_BLOCK_WRITE:
								st <= (byte_count == 8'h00) ?
								      S_DONE : S_FETCH;
							default:
								result <= `UFG_RES_BAD_EP;
						endcase
					end
				end
				S_ISSUE: begin
					FL_ADDR <= op_addr;
					FL_READ <= 1'b1;
					st      <= S_WAIT;
				end
				S_FETCH: begin
					RAM_READ <= 1'b1;
					st       <= S_RAMD;
				end
				// ram registers its answer on the edge after the strobe
				S_RAMD: st <= S_RAMW;
				S_RAMW: begin
					// the byte the ram has just registered
					FL_ADDR  <= op_addr;
					FL_WDATA <= RAM_RDATA;
					FL_WRITE <= 1'b1;
					st       <= S_WAIT;
				end
				S_WAIT: if (FL_DONE) begin
					case (kind)
						`UFG_EP_READ_BYTE: begin
							read_data <= FL_RDATA;
							st        <= S_DONE;
						end
						`UFG_EP_MASS_ERASE: begin
							// mass erase leaves the part in serial mode
							isp_mode <= 1'b1;
							st       <= S_DONE;
						end
						`UFG_EP_BLOCK_READ, `UFG_EP_BLOCK_WRITE: begin
							if (kind == `UFG_EP_BLOCK_READ) begin
								RAM_WRITE <= 1'b1;
								RAM_WDATA <= FL_RDATA;
							end else
								xptr <= xptr + 8'h01;
							op_addr <= op_addr + 16'h0001;
							cnt     <= cnt - 8'h01;
							if (cnt == 8'h01)
								st <= S_DONE;
							else if (kind == `UFG_EP_BLOCK_READ)
								st <= S_ISSUE;
							else
								st <= S_FETCH;
						end
						default: st <= S_DONE;
					endcase
				end
				S_DONE: begin
					WDT_SERVICE  <= 1'b1;
					WDT_LOWER_EN <= 1'b1;
					st           <= S_IDLE;
				end
				default: st <= S_IDLE;
			endcase
		end
	end

endmodule // ufg_gate
`default_nettype wire

//--- core/ufg_map.vh
`ifndef UFG_MAP_VH
`define UFG_MAP_VH

// register word indices; byte address is four times the index
`define UFG_OFS_ADDR_LOW    8'ha8
`define UFG_OFS_ADDR_HIGH   8'ha9
`define UFG_OFS_READ_DATA   8'haa
`define UFG_OFS_WRITE_DATA  8'hab
`define UFG_OFS_WR_TIMING   8'he1
`define UFG_OFS_UNLOCK_KEY  8'he2
`define UFG_OFS_BYTE_COUNT  8'hf1
`define UFG_OFS_CALL        8'hc0
`define UFG_OFS_ACCUM       8'hc1
`define UFG_OFS_CTRL        8'hc2
`define UFG_OFS_STATUS      8'hc3
`define UFG_OFS_XPTR        8'hc4
`define UFG_OFS_IRQ_PEND    8'hc5

// field positions
`define UFG_CTRL_GIE        0
`define UFG_ST_BUSY         0
`define UFG_ST_ISP          1
`define UFG_ST_RES_LO       2
`define UFG_ST_KEY_LIVE     4

// reset value of every software register
`define UFG_RST_REG         8'h00

// key, confirmation code and entry points
`define UFG_KEY_VALUE       8'h98
`define UFG_KEY_WIN_CYC     4'h6
`define UFG_CONFIRM         8'h55
`define UFG_EP_SERIAL       8'h00
`define UFG_EP_READ_BYTE    8'h11
`define UFG_EP_WRITE_BYTE   8'h14
`define UFG_EP_PAGE_ERASE   8'h17
`define UFG_EP_MASS_ERASE   8'h1a
`define UFG_EP_BLOCK_WRITE  8'h23
`define UFG_EP_BLOCK_READ   8'h26
`define UFG_EP_EXIT         8'h62

// call result codes
`define UFG_RES_OK          2'h0
`define UFG_RES_BAD_KEY     2'h1
`define UFG_RES_BAD_CONF    2'h2
`define UFG_RES_BAD_EP      2'h3

// serial programming commands
`define UFG_SER_EXIT        8'h01
`define UFG_SER_MASS_ERASE  8'h02
`define UFG_SER_WR_TIMING   8'h03
`define UFG_SER_RD_OPTION   8'h04

// watchdog service interval
`define UFG_MCLK_MHZ        20
`define UFG_WDT_SVC_US      500
`define UFG_WDT_SVC_CYC     (`UFG_WDT_SVC_US * `UFG_MCLK_MHZ)

`endif

//--- test/ufg_gate_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ufg_gate_props #(
	parameter        NIRQ        = 4,
	parameter [31:0] WDT_SVC_CYC = 32'h8
) (
	// clock, reset and serial side
	input wire logic            MCLK, RST, SEC_BIT, SER_VALID,
	input wire logic [7:0]      SER_CMD,
	// flash strobes and status
	input wire logic            FL_READ, FL_WRITE, FL_PAGE_ERASE,
	input wire logic            FL_MASS_ERASE, CPU_IRQ, WDT_SERVICE,
	input wire logic            WDT_LOWER_EN, SER_ACCEPT, SER_REJECT,
	input wire logic            ISP_MODE, DEV_RESET,
	// interrupts
	input wire logic [NIRQ-1:0] IRQ_SRC, IRQ_PENDING
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	logic        stb;
	logic        in_op;
	logic [31:0] gap;
	assign stb = FL_READ | FL_WRITE | FL_PAGE_ERASE | FL_MASS_ERASE;
	// in_op spans first strobe to the return pulse; gap counts unserviced cycles
	always @(posedge MCLK) begin
		in_op <= !(RST || WDT_LOWER_EN) && (in_op || stb);
		gap <= (RST || WDT_SERVICE || !in_op) ? 32'h0 : gap + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////
	a_irq_blocked: assert property ((stb || in_op) && !WDT_LOWER_EN |-> !CPU_IRQ)
		else $error("interrupt raised during a routine");
	a_wdt_in_window: assert property (gap <= WDT_SVC_CYC + 32'h3)
		else $error("watchdog not serviced in time");
	a_wdt_on_return: assert property (WDT_LOWER_EN |-> WDT_SERVICE)
		else $error("lower window without service");
	a_pend_set_wins: assert property (IRQ_SRC != 0 |=>
		(IRQ_PENDING & $past(IRQ_SRC)) == $past(IRQ_SRC))
		else $error("interrupt source not pending");
	a_ser_accept: assert property (ISP_MODE && SER_VALID &&
		SER_CMD inside {8'h02, 8'h03, 8'h04} |=> SER_ACCEPT && !SER_REJECT)
		else $error("allowed serial command not accepted");
	a_ser_reject: assert property (ISP_MODE && SER_VALID && SEC_BIT &&
		!(SER_CMD inside {[8'h01:8'h04]}) |=> SER_REJECT && !SER_ACCEPT)
		else $error("secured serial command not rejected");
	a_ser_exit: assert property (ISP_MODE && SER_VALID && SER_CMD == 8'h01
		|=> DEV_RESET) else $error("serial exit without reset");
	a_reset_sticky: assert property (DEV_RESET |=> DEV_RESET)
		else $error("reset request dropped");
	a_mode_persists: assert property (ISP_MODE |=> ISP_MODE || DEV_RESET)
		else $error("serial mode left without reset");
	c_mass: cover property (FL_MASS_ERASE);
	c_reject: cover property (SER_REJECT);
	c_irq_after: cover property (WDT_LOWER_EN ##[1:4] CPU_IRQ);
endmodule // ufg_gate_props
`default_nettype wire

//--- test/ufg_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufg_flash_model #(
	parameter int PAGE = 64
) (
	input  wire logic        MCLK, RST,
	input  wire logic [7:0]  lat,
	input  wire logic [15:0] FL_ADDR,
	input  wire logic [7:0]  FL_WDATA, RAM_ADDR, RAM_WDATA,
	input  wire logic        FL_READ, FL_WRITE, FL_PAGE_ERASE,
	input  wire logic        FL_MASS_ERASE, RAM_READ, RAM_WRITE,
	output var  logic [7:0]  FL_RDATA, RAM_RDATA,
	output var  logic        FL_DONE
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  ram [0:255];
	logic [15:0] op_addr;
	logic        stb;
	int          cnt;
	assign stb = FL_READ | FL_WRITE | FL_PAGE_ERASE | FL_MASS_ERASE;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		FL_RDATA = 8'h00;
		RAM_RDATA = 8'h00;
		FL_DONE = 1'b0;
	end
	// data lines toggle when not answering so stale values never pass
	always @(posedge MCLK) begin
		FL_DONE <= 1'b0;
		FL_RDATA <= ~FL_RDATA;
		RAM_RDATA <= ~RAM_RDATA;
		if (RAM_WRITE) ram[RAM_ADDR] <= RAM_WDATA;
		if (RAM_READ) RAM_RDATA <= ram[RAM_ADDR];
		// programming only clears bits, so a rewrite without erase corrupts
		if (FL_WRITE) mem[FL_ADDR] <= mem[FL_ADDR] & FL_WDATA;
		if (FL_PAGE_ERASE) for (int i = 0; i < PAGE; i++)
			mem[16'(FL_ADDR + i)] <= 8'hff;
		if (FL_MASS_ERASE) foreach (mem[i]) mem[i] <= 8'hff;
		if (stb) begin
			cnt <= int'(lat);
			op_addr <= FL_ADDR;
		end else if (cnt == 0) begin
			FL_DONE <= 1'b1;
			FL_RDATA <= mem[op_addr];
		end
		if (!stb && cnt >= 0) cnt <= cnt - 1;
		if (RST) cnt <= -1;
	end
endmodule // ufg_flash_model
`default_nettype wire

//--- test/test_user_flash_isp_call_gate.sv
`timescale 1ns/1ps
`default_nettype none
module test_user_flash_isp_call_gate;
	logic MCLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0;
	logic SEC_BIT = 1, SER_VALID = 0;
	logic [7:0] AVS_ADDRESS = 0, SER_CMD = 0, lat = 1, d, e;
	logic [31:0] AVS_WRITEDATA = 0, rv;
	logic [3:0] IRQ_SRC = 0, IRQ_ACK = 0;
	logic [15:0] a;
	logic [7:0] regs [7] = '{8'ha8, 8'ha9, 8'haa, 8'hab, 8'he1, 8'he2, 8'hf1};
	logic [7:0] cmds [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h11, 8'h05};
	logic [7:0] blk [16];
	int fail_count = 0, checked = 0, n;
	wire [31:0] AVS_READDATA;
	wire [15:0] FL_ADDR;
	wire [7:0] FL_WDATA, FL_TIMING, FL_RDATA, RAM_ADDR, RAM_WDATA, RAM_RDATA;
	wire [3:0] IRQ_PENDING;
	wire AVS_WAITREQUEST, FL_READ, FL_WRITE, FL_PAGE_ERASE, FL_MASS_ERASE;
	wire FL_DONE, RAM_READ, RAM_WRITE, CPU_IRQ, WDT_SERVICE, WDT_LOWER_EN;
	wire SER_ACCEPT, SER_REJECT, ISP_MODE, DEV_RESET;
	ufg_gate #(.NIRQ(4), .WDT_SVC_CYC(32'h8)) i_ufg_gate (.MCLK, .RST,
		.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
		.AVS_WAITREQUEST, .FL_ADDR, .FL_WDATA, .FL_TIMING, .FL_READ, .FL_WRITE,
		.FL_PAGE_ERASE, .FL_MASS_ERASE, .FL_RDATA, .FL_DONE, .RAM_ADDR,
		.RAM_READ, .RAM_WRITE, .RAM_WDATA, .RAM_RDATA, .IRQ_SRC, .IRQ_ACK,
		.IRQ_PENDING, .CPU_IRQ, .WDT_SERVICE, .WDT_LOWER_EN, .SEC_BIT,
		.SER_VALID, .SER_CMD, .SER_ACCEPT, .SER_REJECT, .ISP_MODE, .DEV_RESET);
	ufg_flash_model i_ufg_flash_model (.MCLK, .RST, .lat, .FL_ADDR, .FL_WDATA,
		.RAM_ADDR, .RAM_WDATA, .FL_READ, .FL_WRITE, .FL_PAGE_ERASE,
		.FL_MASS_ERASE, .RAM_READ, .RAM_WRITE, .FL_RDATA, .RAM_RDATA, .FL_DONE);
	always #25 MCLK = ~MCLK;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, x);
		checked++;
		if (g !== x) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// hold the request until the rising edge that sees waitrequest low
	task automatic bus(input logic r, input logic [7:0] ad, dt);
		@(posedge MCLK);
		AVS_ADDRESS <= ad;
		AVS_WRITEDATA <= {24'h0, dt};
		AVS_READ <= r;
		AVS_WRITE <= !r;
		do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
		rv = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	// key edge to call edge is gap plus two cycles
	task automatic call(input logic [7:0] ep, key, input int gap);
		int k;
		bus(0, 8'he2, key);
		repeat (gap) @(posedge MCLK);
		bus(0, 8'hc0, ep);
		k = 0;
		do begin
			bus(1, 8'hc3, 8'h0);
			k++;
		end while (rv[0] !== 1'b0 && k < 300);
		if (k >= 300) fail_count++;
	endtask
	task automatic rst;
		@(posedge MCLK);
		RST <= 1'b1;
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		fail_count++;
		complete_run;
	end
	initial begin
		void'($urandom(32'ha4a582c2));
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
		foreach (regs[i]) begin
			bus(1, regs[i], 8'h0);
			chk(rv, 32'h0);
			d = $urandom;
			bus(0, regs[i], d);
			bus(1, regs[i], 8'h0);
			chk(rv, {24'h0, d});
		end
		bus(0, 8'h10, 8'h5a);
		bus(1, 8'h10, 8'h0);
		chk(rv, 32'h0);
		bus(0, 8'he1, 8'h3c);
		@(negedge MCLK);
		chk(FL_TIMING, 8'h3c);
		a = $urandom;
		d = $urandom;
		lat = $urandom_range(0, 3);
		bus(0, 8'ha8, a[7:0]);
		bus(0, 8'ha9, a[15:8]);
		bus(0, 8'hab, d);
		call(8'h17, 8'h98, 4);
		call(8'h14, 8'h98, 4);
		chk(i_ufg_flash_model.mem[a], d);
		bus(0, 8'hab, ~d);
		call(8'h14, 8'h97, 0);
		chk(rv[3:2], 2'h1);
		call(8'h14, 8'h98, 5);
		chk(rv[3:2], 2'h1);
		chk(i_ufg_flash_model.mem[a], d);
		call(8'h33, 8'h98, 4);
		chk(rv[3:2], 2'h3);
		call(8'h11, 8'h98, 4);
		bus(1, 8'haa, 8'h0);
		chk(rv, {24'h0, d});
		bus(0, 8'hc2, 8'h1);
		lat = 20;
		fork
			call(8'h11, 8'h98, 0);
			begin
				repeat (12) @(posedge MCLK);
				repeat (2) begin
					IRQ_SRC <= 4'h2;
					@(posedge MCLK);
					IRQ_SRC <= 4'h0;
					repeat (3) @(posedge MCLK);
				end
				@(negedge MCLK);
				chk(CPU_IRQ, 1'b0);
			end
		join
		@(negedge MCLK);
		chk({CPU_IRQ, IRQ_PENDING}, 5'h12);
		@(posedge MCLK);
		IRQ_ACK <= 4'h2;
		@(posedge MCLK);
		IRQ_ACK <= 4'h0;
		@(negedge MCLK);
		chk(IRQ_PENDING, 4'h0);
		bus(0, 8'hc2, 8'h0);
		lat = $urandom_range(0, 3);
		n = $urandom_range(1, 16);
		a = {$urandom, 6'h0};
		for (int k = 0; k < 16; k++) blk[k] = $urandom;
		for (int k = 0; k < 16; k++) i_ufg_flash_model.ram[16 + k] = blk[k];
		bus(0, 8'ha8, a[7:0]);
		bus(0, 8'ha9, a[15:8]);
		repeat (2) call(8'h17, 8'h98, 4);
		bus(0, 8'hf1, n[7:0]);
		bus(0, 8'hc4, 8'h10);
		call(8'h23, 8'h98, 4);
		bus(0, 8'hc4, 8'h80);
		call(8'h26, 8'h98, 4);
		for (int k = 0; k < 16; k++) begin
			e = k < n ? blk[k] : 8'hff;
			chk(i_ufg_flash_model.mem[a + k], e);
			if (k < n) chk(i_ufg_flash_model.ram[128 + k], blk[k]);
		end
		bus(0, 8'hc1, 8'h54);
		call(8'h1a, 8'h98, 2);
		chk(rv[3:2], 2'h2);
		bus(0, 8'hc1, 8'h55);
		call(8'h1a, 8'h98, 2);
		chk({ISP_MODE, i_ufg_flash_model.mem[a]}, 9'h1ff);
		for (int k = 0; k < 6; k++) begin
			@(posedge MCLK);
			SER_VALID <= 1'b1;
			SER_CMD <= cmds[k];
			SEC_BIT <= k < 5;
			@(posedge MCLK);
			SER_VALID <= 1'b0;
			@(negedge MCLK);
			chk({SER_ACCEPT, SER_REJECT}, (k < 3 || k == 5) ? 2'h2 : 2'h1);
		end
		@(posedge MCLK);
		SER_VALID <= 1'b1;
		SER_CMD <= 8'h01;
		@(posedge MCLK);
		SER_VALID <= 1'b0;
		@(negedge MCLK);
		chk(DEV_RESET, 1'b1);
		rst;
		foreach (regs[i]) if (i < 2) begin
			call(i ? 8'h00 : 8'h62, 8'h98, 1);
			@(negedge MCLK);
			chk({ISP_MODE, DEV_RESET}, i ? 2'h2 : 2'h1);
			rst;
		end
		complete_run;
	end
endmodule // test_user_flash_isp_call_gate
bind ufg_gate ufg_gate_props #(.NIRQ(NIRQ), .WDT_SVC_CYC(WDT_SVC_CYC))
	i_ufg_gate_props (.MCLK, .RST, .SEC_BIT, .SER_VALID, .SER_CMD, .FL_READ,
	.FL_WRITE, .FL_PAGE_ERASE, .FL_MASS_ERASE, .CPU_IRQ, .WDT_SERVICE,
	.WDT_LOWER_EN, .SER_ACCEPT, .SER_REJECT, .ISP_MODE, .DEV_RESET,
	.IRQ_SRC, .IRQ_PENDING);
`default_nettype wire
